/* File: lcp_led_channel_pwm_control.sv */
// What this block does
// R1 - control bit five selects reduced range: full-scale current one eighth
// R2 - eighteen 8-bit scaling registers at 0x02..0x13, one per channel
// R3 - eighteen 8-bit duty registers at 0x1F..0x30, on-time value/256
// R4 - control register field chooses 200Hz or 25kHz, 8-bit duty both; fast mode here runs at 25000000/768 Hz, about 32.6kHz
// R5 - all channels share one common PWM timebase and start together
// R6 - open-detect enable rising 0 to 1 starts capturing open flags
// R7 - open flags keep refreshing while enable is 1, stop when 0
// R8 - report enable set and any open flag drives fault output low
// R9 - open status readable at 0x95..0x97
// R10 - processor keeps global current between 0x0F and 0x3F for detection
// R11 - spread range field decodes to 5, 15, 24 or 34 percent
// R12 - register contents survive software and hardware shutdown
// R13 - run bit 0 turns all current sources off, registers still usable
// R14 - run bit resets to 0; processor sets it for normal operation
// R15 - hardware shutdown low disables all current sources until high
// R16 - rising shutdown input resets interface state, registers kept
// R17 - registers readable and writable while shutdown input is low
// R18 - scaling applies after 0x36 write, at the PWM period edge
// R19 - duty is staged and applied when 0x00 is written to 0x37
// R20 - each open status register clears when read
// R21 - channel on while free-running counter is below applied duty
`timescale 1ns/100ps
`include "lcp_consts.svh"
module lcp_led_channel_pwm_control (
    input wire logic clk,
    input wire logic reset_n,
    input wire lcp_pkg::lcp_bus_req_t bus_req,
    output logic [7:0] bus_rdata,
    output logic bus_rvalid,
    input wire logic hw_shutdown_n,
    input wire logic [17:0] open_sense,
    output logic [17:0] led_channel_output,
    output logic [143:0] channel_scale,
    output logic [7:0] global_current_level,
    output logic current_range_select,
    output logic spread_enable,
    output logic [5:0] spread_pct,
    output logic current_enable,
    output logic fault_irq_n
);
    localparam int SLOW_DIV = `LCP_CLK_HZ / (`LCP_PWM_SLOW_HZ * `LCP_PWM_STEPS);
    localparam int FAST_DIV = `LCP_CLK_HZ / (`LCP_PWM_FAST_HZ * `LCP_PWM_STEPS);

    lcp_pkg::lcp_if_state_t state_ff;
    logic [7:0] ptr_ff;
    logic sdb_prev_ff;
    logic [7:0] ctrl_ff, gcc_ff, open_ctrl_ff, spread_ff;
    logic [7:0] scale_stage_ff [`LCP_CHANNELS];
    logic [7:0] scale_ff [`LCP_CHANNELS];
    logic [7:0] duty_stage_ff [`LCP_CHANNELS];
    logic [7:0] duty_ff [`LCP_CHANNELS];
    logic scale_pend_ff;
    logic [8:0] presc_ff;
    logic [7:0] pwm_cnt_ff;
    logic ode_prev_ff, detect_on_ff;
    logic [17:0] open_flags_ff;
    logic [7:0] rdata_ff;
    logic rvalid_ff, fault_n_ff, run_en_ff;
    logic [5:0] spread_pct_ff;

    logic sdb_rise, wr_en, rd_en, soft_rst, tick, period_end;
    logic capture, open_detect_enable, open_report_enable;
    logic [8:0] div_last;
    logic [17:0] open_clr;
    logic [7:0] nxt_rdata;

    assign sdb_rise = hw_shutdown_n && !sdb_prev_ff;
    assign wr_en = bus_req.wr && (state_ff == lcp_pkg::LCP_ADDRESSED);
    assign rd_en = bus_req.rd && (state_ff == lcp_pkg::LCP_ADDRESSED);
    assign soft_rst = wr_en && ptr_ff == `LCP_ADDR_SOFT_RESET
        && bus_req.data == `LCP_SOFT_RESET_KEY;
    assign open_detect_enable = open_ctrl_ff[`LCP_OPEN_DET_BIT];
    assign open_report_enable = open_ctrl_ff[`LCP_OPEN_RPT_BIT];

    // serial interface: start loads pointer, each access auto-increments
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            sdb_prev_ff <= 1'b1;
        end else begin
            sdb_prev_ff <= hw_shutdown_n;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_ff <= lcp_pkg::LCP_IDLE;
            ptr_ff <= 8'h00;
        end else begin
            case (state_ff)
                lcp_pkg::LCP_IDLE: begin
                    if (bus_req.start && !sdb_rise) begin
                        state_ff <= lcp_pkg::LCP_ADDRESSED;
                        ptr_ff <= bus_req.data;
                    end
                end
                lcp_pkg::LCP_ADDRESSED: begin
                    if (sdb_rise) begin
                        state_ff <= lcp_pkg::LCP_IDLE; // see R16
                    end else if (bus_req.start) begin
                        ptr_ff <= bus_req.data;
                    end else if (bus_req.wr || bus_req.rd) begin
                        ptr_ff <= ptr_ff + 8'h01;
                    end
                end
                default: begin
                    state_ff <= lcp_pkg::LCP_IDLE;
                end
            endcase
        end
    end

    // control registers; no shutdown term here, so contents survive it
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ctrl_ff <= `LCP_CTRL_RST; // see R14
            gcc_ff <= `LCP_GCC_RST;
            open_ctrl_ff <= `LCP_OPEN_CTRL_RST;
            spread_ff <= `LCP_SPREAD_RST;
        end else if (soft_rst) begin
            ctrl_ff <= `LCP_CTRL_RST;
            gcc_ff <= `LCP_GCC_RST;
            open_ctrl_ff <= `LCP_OPEN_CTRL_RST;
            spread_ff <= `LCP_SPREAD_RST;
        end else if (wr_en) begin // see R12 see R17
            case (ptr_ff)
                `LCP_ADDR_CTRL: ctrl_ff <= bus_req.data;
                `LCP_ADDR_GCC: gcc_ff <= bus_req.data;
                `LCP_ADDR_OPEN_CTRL: open_ctrl_ff <= bus_req.data;
                `LCP_ADDR_SPREAD: spread_ff <= bus_req.data;
                default: begin
                end
            endcase
        end
    end

    // scaling: staged, armed by the scaling update key, applied at period end
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            scale_pend_ff <= 1'b0;
            for (int i = 0; i < `LCP_CHANNELS; i++) begin
                scale_stage_ff[i] <= `LCP_SCALE_RST;
                scale_ff[i] <= `LCP_SCALE_RST;
            end
        end else if (soft_rst) begin
            scale_pend_ff <= 1'b0;
            for (int i = 0; i < `LCP_CHANNELS; i++) begin
                scale_stage_ff[i] <= `LCP_SCALE_RST;
                scale_ff[i] <= `LCP_SCALE_RST;
            end
        end else begin
            for (int i = 0; i < `LCP_CHANNELS; i++) begin
                if (wr_en && ptr_ff == `LCP_ADDR_SCALE_BASE + 8'(i)) begin
                    scale_stage_ff[i] <= bus_req.data; // see R2
                end
                if (scale_pend_ff && period_end) begin
                    scale_ff[i] <= scale_stage_ff[i]; // see R18
                end
            end
            if (wr_en && ptr_ff == `LCP_ADDR_SCALE_UPD
                && bus_req.data == `LCP_UPDATE_KEY) begin
                scale_pend_ff <= 1'b1; // see R18
            end else if (period_end) begin
                scale_pend_ff <= 1'b0;
            end
        end
    end

    // duty: staged, applied at once by the update key
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            for (int i = 0; i < `LCP_CHANNELS; i++) begin
                duty_stage_ff[i] <= `LCP_DUTY_RST;
                duty_ff[i] <= `LCP_DUTY_RST;
            end
        end else if (soft_rst) begin
            for (int i = 0; i < `LCP_CHANNELS; i++) begin
                duty_stage_ff[i] <= `LCP_DUTY_RST;
                duty_ff[i] <= `LCP_DUTY_RST;
            end
        end else begin
            for (int i = 0; i < `LCP_CHANNELS; i++) begin
                if (wr_en && ptr_ff == `LCP_ADDR_DUTY_BASE + 8'(i)) begin
                    duty_stage_ff[i] <= bus_req.data; // see R3
                end
                if (wr_en && ptr_ff == `LCP_ADDR_UPDATE
                    && bus_req.data == `LCP_UPDATE_KEY) begin
                    duty_ff[i] <= duty_stage_ff[i]; // see R19
                end
            end
        end
    end

    // common timebase; divider rounds down so the rate is never too slow
    assign div_last = ctrl_ff[`LCP_CTRL_FAST_BIT] ? 9'(FAST_DIV - 1)
        : 9'(SLOW_DIV - 1); // see R4
    assign tick = (presc_ff >= div_last);
    assign period_end = tick && (pwm_cnt_ff == 8'hFF);

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            presc_ff <= 9'h000;
            pwm_cnt_ff <= 8'h00;
        end else begin
            presc_ff <= tick ? 9'h000 : presc_ff + 9'h001;
            if (tick) begin
                pwm_cnt_ff <= pwm_cnt_ff + 8'h01; // see R5
            end
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            run_en_ff <= 1'b0;
        end else begin
            run_en_ff <= ctrl_ff[`LCP_CTRL_RUN_BIT] && hw_shutdown_n; // see R13 see R15
        end
    end

    for (genvar g = 0; g < `LCP_CHANNELS; g++) begin : g_chan
        lcp_pwm_channel u_chan (
            .clk(clk),
            .reset_n(reset_n),
            .count(pwm_cnt_ff),
            .duty(duty_ff[g]),
            .enable(ctrl_ff[`LCP_CTRL_RUN_BIT] && hw_shutdown_n), // see R5
            .drive(led_channel_output[g])
        );
        assign channel_scale[g*8 +: 8] = scale_ff[g];
    end

    // open detection; a new open seen in a read cycle survives the clear
    assign capture = detect_on_ff && open_detect_enable;
    always_comb begin
        open_clr = 18'h0_0000;
        for (int k = 0; k < `LCP_OPEN_REGS; k++) begin
            if (rd_en && ptr_ff == `LCP_ADDR_OPEN_BASE + 8'(k)) begin
                open_clr[k*6 +: 6] = 6'h3F; // see R20
            end
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ode_prev_ff <= 1'b0;
            detect_on_ff <= 1'b0;
            open_flags_ff <= 18'h0_0000;
        end else begin
            ode_prev_ff <= open_detect_enable;
            if (open_detect_enable && !ode_prev_ff) begin
                detect_on_ff <= 1'b1; // see R6
            end else if (!open_detect_enable) begin
                detect_on_ff <= 1'b0; // see R7
            end
            open_flags_ff <= (open_flags_ff & ~open_clr)
                | (capture ? open_sense : 18'h0_0000); // see R7
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            fault_n_ff <= 1'b1;
        end else begin
            fault_n_ff <= !(open_report_enable && (|open_flags_ff)); // see R8
        end
    end

    // read data
    always_comb begin
        nxt_rdata = 8'h00;
        for (int i = 0; i < `LCP_CHANNELS; i++) begin
            if (ptr_ff == `LCP_ADDR_SCALE_BASE + 8'(i)) begin
                nxt_rdata = scale_stage_ff[i];
            end
            if (ptr_ff == `LCP_ADDR_DUTY_BASE + 8'(i)) begin
                nxt_rdata = duty_stage_ff[i];
            end
        end
        for (int k = 0; k < `LCP_OPEN_REGS; k++) begin
            if (ptr_ff == `LCP_ADDR_OPEN_BASE + 8'(k)) begin
                nxt_rdata = {1'b0, open_flags_ff[k*6+3 +: 3], 1'b0,
                    open_flags_ff[k*6 +: 3]}; // see R9
            end
        end
        case (ptr_ff)
            `LCP_ADDR_CTRL: nxt_rdata = ctrl_ff;
            `LCP_ADDR_GCC: nxt_rdata = gcc_ff;
            `LCP_ADDR_OPEN_CTRL: nxt_rdata = open_ctrl_ff;
            `LCP_ADDR_SPREAD: nxt_rdata = spread_ff;
            default: begin
            end
        endcase
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rdata_ff <= 8'h00;
            rvalid_ff <= 1'b0;
        end else begin
            rvalid_ff <= rd_en;
            if (rd_en) begin
                rdata_ff <= nxt_rdata;
            end
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            spread_pct_ff <= `LCP_SPREAD_PCT0;
        end else begin
            case (spread_ff[`LCP_SPREAD_RNG_LSB +: 2]) // see R11
                2'b00: spread_pct_ff <= `LCP_SPREAD_PCT0;
                2'b01: spread_pct_ff <= `LCP_SPREAD_PCT1;
                2'b10: spread_pct_ff <= `LCP_SPREAD_PCT2;
                default: spread_pct_ff <= `LCP_SPREAD_PCT3;
            endcase
        end
    end

    assign bus_rdata = rdata_ff;
    assign bus_rvalid = rvalid_ff;
    assign global_current_level = gcc_ff; // see R10
    assign current_range_select = ctrl_ff[`LCP_CTRL_RANGE_BIT]; // see R1
    assign spread_enable = spread_ff[`LCP_SPREAD_EN_BIT];
    assign spread_pct = spread_pct_ff;
    assign current_enable = run_en_ff;
    assign fault_irq_n = fault_n_ff;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    property p_soft_off;
        !ctrl_ff[`LCP_CTRL_RUN_BIT] |=> ##1 (led_channel_output == 18'h0_0000);
    endproperty
    a_soft_off: assert property (p_soft_off) // see R13
        else $error("channel on during software shutdown");

    property p_hw_off;
        !hw_shutdown_n |=> (led_channel_output == 18'h0_0000) && !current_enable;
    endproperty
    a_hw_off: assert property (p_hw_off) // see R15
        else $error("channel on during hardware shutdown");

    property p_sdb_rise_idle;
        sdb_rise |=> state_ff == lcp_pkg::LCP_IDLE;
    endproperty
    a_sdb_rise_idle: assert property (p_sdb_rise_idle) // see R16
        else $error("interface not reset on shutdown release");

    property p_fault_low;
        (open_report_enable && |open_flags_ff) |=> !fault_irq_n;
    endproperty
    a_fault_low: assert property (p_fault_low) // see R8
        else $error("open not reported on fault output");

    property p_fault_quiet;
        !open_report_enable |=> fault_irq_n;
    endproperty
    a_fault_quiet: assert property (p_fault_quiet) // see R8
        else $error("fault output low with reporting disabled");

    property p_read_clear;
        (rd_en && ptr_ff == `LCP_ADDR_OPEN_BASE && !capture)
            |=> open_flags_ff[5:0] == 6'h00;
    endproperty
    a_read_clear: assert property (p_read_clear) // see R20
        else $error("open status not cleared by read");

    property p_scale_at_edge;
        !$stable(channel_scale)
            |-> $past((period_end && scale_pend_ff) || soft_rst);
    endproperty
    a_scale_at_edge: assert property (p_scale_at_edge) // see R18
        else $error("scaling changed outside period edge");

    property p_shutdown_write;
        (wr_en && ptr_ff == `LCP_ADDR_GCC && !hw_shutdown_n)
            |=> global_current_level == $past(bus_req.data);
    endproperty
    a_shutdown_write: assert property (p_shutdown_write) // see R17
        else $error("write lost during hardware shutdown");

    property p_spread_max;
        spread_ff[`LCP_SPREAD_RNG_LSB +: 2] == 2'b11
            |=> spread_pct == `LCP_SPREAD_PCT3;
    endproperty
    a_spread_max: assert property (p_spread_max) // see R11
        else $error("spread range decode wrong");

endmodule : lcp_led_channel_pwm_control

/* File: lcp_consts.svh */
`ifndef LCP_CONSTS_SVH
`define LCP_CONSTS_SVH

// register addresses
`define LCP_ADDR_CTRL 8'h00
`define LCP_ADDR_GCC 8'h01
`define LCP_ADDR_SCALE_BASE 8'h02
`define LCP_ADDR_SCALE_LAST 8'h13
`define LCP_ADDR_OPEN_CTRL 8'h14
`define LCP_ADDR_SPREAD 8'h19
`define LCP_ADDR_DUTY_BASE 8'h1F
`define LCP_ADDR_DUTY_LAST 8'h30
`define LCP_ADDR_SCALE_UPD 8'h36
`define LCP_ADDR_UPDATE 8'h37
`define LCP_ADDR_SOFT_RESET 8'h3F
`define LCP_ADDR_OPEN_BASE 8'h95
`define LCP_ADDR_OPEN_LAST 8'h97

// command values
`define LCP_UPDATE_KEY 8'h00
`define LCP_SOFT_RESET_KEY 8'hAE

// field positions
`define LCP_CTRL_RUN_BIT 0
`define LCP_CTRL_FAST_BIT 1
`define LCP_CTRL_RANGE_BIT 5
`define LCP_OPEN_DET_BIT 0
`define LCP_OPEN_RPT_BIT 1
`define LCP_SPREAD_EN_BIT 4
`define LCP_SPREAD_RNG_LSB 2

// reset values
`define LCP_CTRL_RST 8'h00
`define LCP_GCC_RST 8'h00
`define LCP_SCALE_RST 8'hFF
`define LCP_OPEN_CTRL_RST 8'h03
`define LCP_SPREAD_RST 8'h00
`define LCP_DUTY_RST 8'h00

// spreading range in percent
`define LCP_SPREAD_PCT0 6'd5
`define LCP_SPREAD_PCT1 6'd15
`define LCP_SPREAD_PCT2 6'd24
`define LCP_SPREAD_PCT3 6'd34

// timing
`define LCP_CLK_HZ 25000000
`define LCP_PWM_SLOW_HZ 200
`define LCP_PWM_FAST_HZ 25000
`define LCP_PWM_STEPS 256
`define LCP_CHANNELS 18
`define LCP_OPEN_REGS 3

`endif

/* File: lcp_pkg.sv */
package lcp_pkg;

    typedef struct packed {
        logic start;
        logic wr;
        logic rd;
        logic [7:0] data;
    } lcp_bus_req_t;

    typedef enum logic [1:0] {
        LCP_IDLE = 2'b01,
        LCP_ADDRESSED = 2'b10
    } lcp_if_state_t;

endpackage : lcp_pkg

/* File: lcp_pwm_channel.sv */
`timescale 1ns/100ps
module lcp_pwm_channel (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [7:0] count,
    input wire logic [7:0] duty,
    input wire logic enable,
    output logic drive
);
    logic drive_ff;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            drive_ff <= 1'b0;
        end else begin
            drive_ff <= enable && (count < duty); // see R21 see R3
        end
    end

    assign drive = drive_ff;

    property p_on_below_duty;
        @(posedge clk) disable iff (!reset_n)
        (enable && count < duty) |=> drive;
    endproperty
    a_on_below_duty: assert property (p_on_below_duty) // see R21
        else $error("channel off while count below duty");

    property p_off_at_duty;
        @(posedge clk) disable iff (!reset_n)
        (count >= duty || !enable) |=> !drive;
    endproperty
    a_off_at_duty: assert property (p_off_at_duty) // see R3
        else $error("channel on while count at or above duty");

endmodule : lcp_pwm_channel

/* File: lcp_proc_model.sv */
`timescale 1ns/100ps
`include "lcp_consts.svh"
module lcp_proc_model (
    input wire logic clk,
    output lcp_pkg::lcp_bus_req_t bus_req
);
    // slow inserts an idle cycle between the address phase and the access
    logic slow;

    initial begin
        bus_req = '0;
        slow = 1'b0;
    end

    // one request per rising edge, held for exactly one cycle
    task automatic put(input logic s, input logic w, input logic r,
                       input logic [7:0] d);
        @(posedge clk);
        bus_req <= '{s, w, r, d};
    endtask : put

    task automatic point(input logic [7:0] a);
        put(1'b1, 1'b0, 1'b0, a);
        if (slow) begin
            put(1'b0, 1'b0, 1'b0, ~a);
        end
    endtask : point

    // released data lines show the inverse, never a stale copy
    task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
        point(a);
        put(1'b0, 1'b1, 1'b0, d);
        put(1'b0, 1'b0, 1'b0, ~d);
    endtask : write_reg

    task automatic read_reg(input logic [7:0] a);
        point(a);
        put(1'b0, 1'b0, 1'b1, ~a);
        put(1'b0, 1'b0, 1'b0, a);
    endtask : read_reg

    task automatic bring_up(input logic [7:0] ctrl);
        write_reg(`LCP_ADDR_GCC, 8'h20);
        write_reg(`LCP_ADDR_CTRL, ctrl);
    endtask : bring_up

    task automatic apply_scale;
        write_reg(`LCP_ADDR_SCALE_UPD, `LCP_UPDATE_KEY);
    endtask : apply_scale

    task automatic apply_duty;
        write_reg(`LCP_ADDR_UPDATE, `LCP_UPDATE_KEY);
    endtask : apply_duty
endmodule : lcp_proc_model

/* File: lcp_led_channel_pwm_control_tb.sv */
`timescale 1ns/100ps
`include "lcp_consts.svh"
`define CHK(nm, ex, got) begin \
    cmp_count++; \
    if ((got) !== (ex)) begin \
        failures++; \
        $display("[FAIL] %s expected %0h seen %0h", nm, ex, got); \
    end \
end
module lcp_led_channel_pwm_control_tb;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic hw_shutdown_n = 1'b1;
    logic [17:0] open_sense = '0;
    lcp_pkg::lcp_bus_req_t bus_req;
    logic [7:0] bus_rdata;
    logic bus_rvalid;
    logic [17:0] led_channel_output;
    logic [143:0] channel_scale;
    logic [7:0] global_current_level;
    logic current_range_select;
    logic spread_enable;
    logic [5:0] spread_pct;
    logic current_enable;
    logic fault_irq_n;
    int failures = 0;
    int cmp_count = 0;
    int seed = 45647;
    int hi[5];
    logic [7:0] ev;
    logic [7:0] sv;
    logic [7:0] exp_q[$];
    logic [7:0] dt[4];
    logic [7:0] ra[10] = '{8'h00, 8'h01, 8'h02, 8'h13, 8'h14, 8'h19,
                           8'h1F, 8'h30, 8'h95, 8'h50};
    logic [7:0] rv[10] = '{8'h00, 8'h00, 8'hFF, 8'hFF, 8'h03, 8'h00,
                           8'h00, 8'h00, 8'h00, 8'h00};
    logic [5:0] pct[4] = '{6'd5, 6'd15, 6'd24, 6'd34};

    always #20 clk = ~clk;

    lcp_proc_model proc (.clk(clk), .bus_req(bus_req));

    lcp_led_channel_pwm_control dut (
        .clk(clk), .reset_n(reset_n), .bus_req(bus_req),
        .bus_rdata(bus_rdata), .bus_rvalid(bus_rvalid),
        .hw_shutdown_n(hw_shutdown_n), .open_sense(open_sense),
        .led_channel_output(led_channel_output),
        .channel_scale(channel_scale),
        .global_current_level(global_current_level),
        .current_range_select(current_range_select),
        .spread_enable(spread_enable), .spread_pct(spread_pct),
        .current_enable(current_enable), .fault_irq_n(fault_irq_n)
    );

    task automatic stop_test;
        $display("counts: %0d compares, %0d failures", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : stop_test

    task automatic fail_out(input string what);
        failures++;
        $display("[FAIL] %s expected done seen timeout", what);
        stop_test();
    endtask : fail_out

    // answers arrive in request order, so the oldest note matches
    always @(posedge clk) begin
        if (bus_rvalid === 1'b1) begin
            if (exp_q.size() == 0) begin
                fail_out("read answer");
            end else begin
                ev = exp_q.pop_front();
                `CHK("read data", ev, bus_rdata)
            end
        end
    end

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        proc.read_reg(a);
    endtask : rd

    task automatic drain;
        for (int i = 0; i < 20 && exp_q.size() != 0; i++) begin
            @(posedge clk);
        end
        if (exp_q.size() != 0) begin
            fail_out("read queue");
        end
    endtask : drain

    // one fast period is 256 steps of 3 clocks
    task automatic measure;
        hi = '{0, 0, 0, 0, 0};
        // skip two edges; the first still shows output from the old duty
        repeat (2) @(posedge clk);
        repeat (768) begin
            @(posedge clk);
            for (int c = 0; c < 4; c++) begin
                hi[c] += int'(led_channel_output[c]);
            end
            hi[4] += int'(led_channel_output[0] !== led_channel_output[1]);
        end
    endtask : measure

    initial begin
        #4_000_000;
        fail_out("run length");
    end

    initial begin
        repeat (12) @(posedge clk);
        reset_n <= 1'b1;
        @(posedge clk);
        `CHK("current_enable", 1'b0, current_enable)
        `CHK("fault_irq_n", 1'b1, fault_irq_n)
        `CHK("channel_scale", {18{8'hFF}}, channel_scale)
        `CHK("spread_pct", 6'd5, spread_pct)
        proc.write_reg(8'h95, 8'h77);
        proc.write_reg(8'h50, 8'h55);
        foreach (ra[i]) rd(ra[i], rv[i]);
        drain();
        $display("test reset values done");

        proc.bring_up(8'h23);
        repeat (3) @(posedge clk);
        `CHK("current_enable", 1'b1, current_enable)
        `CHK("current_range_select", 1'b1, current_range_select)
        `CHK("global_current_level", 8'h20, global_current_level)
        proc.write_reg(`LCP_ADDR_CTRL, 8'h22);
        repeat (3) @(posedge clk);
        `CHK("current_enable", 1'b0, current_enable)
        rd(`LCP_ADDR_CTRL, 8'h22);
        drain();
        proc.write_reg(`LCP_ADDR_CTRL, 8'h23);
        for (int r = 0; r < 4; r++) begin
            proc.write_reg(`LCP_ADDR_SPREAD, 8'h10 | 8'(r << 2));
            repeat (2) @(posedge clk);
            `CHK("spread_pct", pct[r], spread_pct)
            `CHK("spread_enable", 1'b1, spread_enable)
        end
        $display("test control fields done");

        sv = 8'($random(seed)) & 8'h7F;
        proc.write_reg(8'h02, sv);
        proc.write_reg(8'h13, 8'h5A);
        repeat (800) @(posedge clk);
        `CHK("scale held", 8'hFF, channel_scale[7:0])
        rd(8'h02, sv);
        drain();
        proc.apply_scale();
        for (int i = 0; i < 900 && channel_scale[7:0] !== sv; i++) begin
            @(posedge clk);
        end
        `CHK("scale ch1", sv, channel_scale[7:0])
        `CHK("scale ch2", 8'hFF, channel_scale[15:8])
        `CHK("scale ch18", 8'h5A, channel_scale[143:136])
        $display("test scaling done");

        dt = '{8'($random(seed)), 8'($random(seed)), 8'h00, 8'hFF};
        for (int c = 0; c < 4; c++) begin
            proc.write_reg(8'h1F + 8'(c), dt[c]);
        end
        measure();
        `CHK("duty staged", 0, hi[0])
        proc.apply_duty();
        measure();
        for (int c = 0; c < 4; c++) begin
            `CHK("on time", 3 * int'(dt[c]), hi[c])
        end
        `CHK("common start", 3 * (dt[0] > dt[1] ? dt[0] - dt[1] :
            dt[1] - dt[0]), hi[4])
        $display("test duty done");

        hw_shutdown_n <= 1'b0;
        repeat (3) @(posedge clk);
        `CHK("current_enable", 1'b0, current_enable)
        proc.write_reg(`LCP_ADDR_GCC, 8'h3F);
        repeat (2) @(posedge clk);
        `CHK("gcc in shutdown", 8'h3F, global_current_level)
        hw_shutdown_n <= 1'b1;
        repeat (3) @(posedge clk);
        proc.put(1'b0, 1'b1, 1'b0, 8'h11);
        proc.put(1'b0, 1'b0, 1'b0, 8'hEE);
        rd(8'h02, sv);
        drain();
        `CHK("current_enable", 1'b1, current_enable)
        `CHK("gcc kept", 8'h3F, global_current_level)
        `CHK("scale kept", sv, channel_scale[7:0])
        $display("test shutdown done");

        proc.slow = 1'b1;
        open_sense <= 18'h00011;
        repeat (4) @(posedge clk);
        `CHK("fault_irq_n", 1'b0, fault_irq_n)
        rd(`LCP_ADDR_OPEN_BASE, 8'h21);
        drain();
        proc.write_reg(`LCP_ADDR_OPEN_CTRL, 8'h02);
        rd(`LCP_ADDR_OPEN_BASE, 8'h21);
        rd(`LCP_ADDR_OPEN_BASE, 8'h00);
        drain();
        repeat (2) @(posedge clk);
        `CHK("fault_irq_n", 1'b1, fault_irq_n)
        proc.write_reg(`LCP_ADDR_OPEN_CTRL, 8'h01);
        repeat (4) @(posedge clk);
        `CHK("fault_irq_n", 1'b1, fault_irq_n)
        rd(`LCP_ADDR_OPEN_BASE, 8'h21);
        drain();
        $display("test open detect done");

        proc.write_reg(`LCP_ADDR_SOFT_RESET, `LCP_SOFT_RESET_KEY);
        rd(`LCP_ADDR_GCC, `LCP_GCC_RST);
        rd(`LCP_ADDR_CTRL, `LCP_CTRL_RST);
        drain();
        `CHK("scale reset", {18{8'hFF}}, channel_scale)
        $display("test soft reset done");
        stop_test();
    end
endmodule : lcp_led_channel_pwm_control_tb
